/* rtl/pix_pkg.sv */
// constants and types shared by the pixel output pipeline
package pix_pkg;
  localparam logic [11:0] PIX_MAX = 12'hFFF;
  localparam logic [3:0] WIDTH_8 = 4'h8;
  localparam logic [3:0] WIDTH_10 = 4'hA;
  localparam logic [3:0] WIDTH_12 = 4'hC;
  localparam logic [3:0] TAPS_2 = 4'h2;
  localparam logic [3:0] TAPS_4 = 4'h4;
  localparam logic [3:0] TAPS_8 = 4'h8;
  localparam logic [3:0] TAPS_10 = 4'hA;
  localparam int MAX_TAPS = 10;
  localparam logic [7:0] LINK_MHZ_FAST = 8'h55;
  localparam logic [7:0] LINK_MHZ_SLOW = 8'h41;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AWB = 8'h04;
  localparam logic [7:0] OFF_WB_X = 8'h08;
  localparam logic [7:0] OFF_WB_Y = 8'h0C;
  localparam logic [7:0] OFF_WB_W = 8'h10;
  localparam logic [7:0] OFF_WB_H = 8'h14;
  localparam logic [7:0] OFF_GAIN_R = 8'h18;
  localparam logic [7:0] OFF_GAIN_G = 8'h1C;
  localparam logic [7:0] OFF_GAIN_B = 8'h20;
  localparam logic [7:0] OFF_DGAIN = 8'h24;
  localparam logic [7:0] OFF_BLACK = 8'h28;
  localparam logic [7:0] OFF_THR_HI = 8'h2C;
  localparam logic [7:0] OFF_THR_LO = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h34;
  // control field positions
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_TAPS_LSB = 4;
  localparam int CTRL_SPEED_BIT = 8;
  localparam int CTRL_HOT_BIT = 9;
  localparam int CTRL_DPC_BIT = 10;
  // gains carry 8 fraction bits
  localparam logic [13:0] GAIN_ONE = 14'h0100;
  localparam logic [13:0] CGAIN_MAX = 14'h0400;
  localparam logic [13:0] DGAIN_MAX = 14'h2000;
  localparam logic [11:0] THR_MAX = 12'h800;
  localparam logic [15:0] WIDEN_DIV = 16'h0005;
  localparam int SUM_W = 40;
  localparam int CNT_W = 28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] COL_R = 2'h0;
  localparam logic [1:0] COL_B = 2'h2;
  typedef struct packed {
    logic sof;
    logic [15:0] x;
    logic [15:0] y;
    logic [1:0] colour;
    logic [8:0][11:0] win;
  } pix_in_t;
  typedef struct packed {
    logic dval;
    logic [MAX_TAPS-1:0][11:0] taps;
  } link_out_t;
  typedef enum logic [1:0] {AWB_IDLE, AWB_ARMED, AWB_GATHER, AWB_SOLVE}
    awb_state_t;
endpackage : pix_pkg

/* rtl/pix_gain_sat.sv */
// saturating fixed-point gain stage
`timescale 1ns/1ps
`default_nettype none
module pix_gain_sat import pix_pkg::*; (
  input wire logic [11:0] pix_in, // pixel on 12-bit scale
  input wire logic [13:0] gain_in, // gain with 8 fraction bits
  output logic [11:0] pix_out // scaled pixel
);
  logic [25:0] prod;
  logic [17:0] scaled;
  assign prod = 26'(pix_in) * 26'(gain_in);
  assign scaled = prod[25:8];
  assign pix_out = (scaled > 18'(PIX_MAX)) ? PIX_MAX : scaled[11:0];
endmodule : pix_gain_sat
`default_nettype wire

/* rtl/pix_median.sv */
// hot pixel and dynamic defect correction on a 3x3 window
`timescale 1ns/1ps
`default_nettype none
module pix_median import pix_pkg::*; (
  input wire logic [8:0][11:0] win_in, // window, centre at 4
  input wire logic hot_en_in, // hot pixel removal on
  input wire logic dpc_en_in, // dynamic defect fix on
  input wire logic [11:0] thr_hi_in, // upper offset threshold
  input wire logic [11:0] thr_lo_in, // lower offset threshold
  output logic [11:0] pix_out // corrected centre pixel
);
  // rank select: the element with at most four below it and at least five at or below
  function automatic logic [11:0] median9(input logic [8:0][11:0] w);
    logic [11:0] m;
    int lt;
    int le;
    m = w[4];
    for (int i = 0; i < 9; i++) begin
      lt = 0;
      le = 0;
      for (int j = 0; j < 9; j++) begin
        if (w[j] < w[i]) lt++;
        if (w[j] <= w[i]) le++;
      end
      if (lt <= 4 && le >= 5) m = w[i];
    end
    return m;
  endfunction : median9

  logic [15:0] sum9;
  logic [11:0] avg, fifth, nb_max, med, centre;
  logic [13:0] hi_lim, lo_side;
  logic too_hi, too_lo, hot;
  // neighbourhood statistics
  always_comb begin
    sum9 = 16'h0000;
    nb_max = 12'h000;
    for (int i = 0; i < 9; i++) begin
      sum9 = sum9 + 16'(win_in[i]);
      if (i != 4 && win_in[i] > nb_max) nb_max = win_in[i];
    end
  end
  assign centre = win_in[4];
  assign avg = 12'(sum9 / 16'h0009);
  assign fifth = 12'(16'(avg) / WIDEN_DIV);
  assign med = median9(win_in);
  // window of average plus or minus 20 percent and offset
  assign hi_lim = 14'(avg) + 14'(fifth) + 14'(thr_hi_in);
  assign lo_side = 14'(centre) + 14'(fifth) + 14'(thr_lo_in);
  assign too_hi = 14'(centre) > hi_lim;
  assign too_lo = lo_side < 14'(avg);
  // hot pixel clipped to brightest neighbour
  assign hot = hot_en_in && centre > nb_max;
  // median replaces outliers only when enabled
  assign pix_out = (dpc_en_in && (too_hi || too_lo)) ? med :
                   hot ? nb_max : centre;
endmodule : pix_median
`default_nettype wire

/* rtl/camera_pixel_output_pipeline.sv */
// pixel output pipeline: register slave, correction, gains, tap packing
`timescale 1ns/1ps
`default_nettype none
module camera_pixel_output_pipeline import pix_pkg::*; (
  input wire logic CLK_IN, // 40 MHz system clock
  input wire logic RESET_IN, // synchronous, active high
  input wire logic [7:0] S_AXI_AWADDR_IN, // write address
  input wire logic S_AXI_AWVALID_IN, // write address valid
  output logic S_AXI_AWREADY_OUT, // write address ready
  input wire logic [31:0] S_AXI_WDATA_IN, // write data
  input wire logic [3:0] S_AXI_WSTRB_IN, // write byte enables
  input wire logic S_AXI_WVALID_IN, // write data valid
  output logic S_AXI_WREADY_OUT, // write data ready
  output logic [1:0] S_AXI_BRESP_OUT, // write response
  output logic S_AXI_BVALID_OUT, // write response valid
  input wire logic S_AXI_BREADY_IN, // write response ready
  input wire logic [7:0] S_AXI_ARADDR_IN, // read address
  input wire logic S_AXI_ARVALID_IN, // read address valid
  output logic S_AXI_ARREADY_OUT, // read address ready
  output logic [31:0] S_AXI_RDATA_OUT, // read data
  output logic [1:0] S_AXI_RRESP_OUT, // read response
  output logic S_AXI_RVALID_OUT, // read data valid
  input wire logic S_AXI_RREADY_IN, // read data ready
  input wire pix_in_t PIX_IN, // raw pixel with its 3x3 window
  input wire logic PIX_VALID_IN, // pixel offered
  output logic PIX_READY_OUT, // pixel can be taken
  input wire logic LINK_CLK_IN, // link pixel clock, asynchronous
  output link_out_t LINK_OUT, // tap word with data valid
  output logic LINK_CLK_SEL_OUT // link clock select, 0 is fast
);
  logic [3:0] width_ff, taps_ff, cnt_ff;
  logic speed_ff, hot_ff, dpc_ff;
  logic [15:0] wb_x_ff, wb_y_ff, wb_w_ff, wb_h_ff;
  logic [13:0] gain_r_ff, gain_g_ff, gain_b_ff, dgain_ff, col_gain;
  logic [7:0] black_ff;
  logic [11:0] thr_hi_ff, thr_lo_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wr_word, rd_word;
  logic [7:0] wr_addr, rd_addr, link_mhz;
  logic wr_go, rd_go, awb_req, awb_busy;
  awb_state_t awb_st_ff, nxt_awb_st;
  logic [2:0][SUM_W-1:0] sum_ff;
  logic [2:0][CNT_W-1:0] num_ff;
  logic [1:0] col_idx;
  logic [16:0] x_end, y_end;
  logic in_wb, wb_set, stat_en, pix_take;
  logic [11:0] fixed_pix, wb_pix, dg_pix, blk_pix, out_pix;
  logic [12:0] blk_sum;
  logic [MAX_TAPS-1:0][11:0] slot_ff, hold_taps_ff, nxt_word;
  logic hold_full_ff, last_tap, word_done;
  logic lk_s1_ff, lk_s2_ff, lk_s3_ff, link_rise;
  link_out_t link_ff;

  function automatic logic reg_known(input logic [7:0] a);
    return a inside {OFF_CTRL, OFF_AWB, OFF_WB_X, OFF_WB_Y, OFF_WB_W,
      OFF_WB_H, OFF_GAIN_R, OFF_GAIN_G, OFF_GAIN_B, OFF_DGAIN,
      OFF_BLACK, OFF_THR_HI, OFF_THR_LO, OFF_STATUS};
  endfunction : reg_known

  function automatic logic [13:0] clamp(input logic [13:0] v,
      input logic [13:0] lo, input logic [13:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clamp

  // current value of a register, shared by reads and masked writes
  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL: v = {21'h0, dpc_ff, hot_ff, speed_ff, taps_ff, width_ff};
      OFF_AWB: v = {31'h0, awb_busy};
      OFF_WB_X: v = {16'h0, wb_x_ff};
      OFF_WB_Y: v = {16'h0, wb_y_ff};
      OFF_WB_W: v = {16'h0, wb_w_ff};
      OFF_WB_H: v = {16'h0, wb_h_ff};
      OFF_GAIN_R: v = {18'h0, gain_r_ff};
      OFF_GAIN_G: v = {18'h0, gain_g_ff};
      OFF_GAIN_B: v = {18'h0, gain_b_ff};
      OFF_DGAIN: v = {18'h0, dgain_ff};
      OFF_BLACK: v = {24'h0, black_ff};
      OFF_THR_HI: v = {20'h0, thr_hi_ff};
      OFF_THR_LO: v = {20'h0, thr_lo_ff};
      OFF_STATUS: v = {16'h0, link_mhz, 7'h0, awb_busy};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_value

  // grey world: colour gain = mean(green) / mean(colour)
  function automatic logic [13:0] grey_gain(input logic [SUM_W-1:0] gs,
      input logic [CNT_W-1:0] gc, input logic [SUM_W-1:0] cs,
      input logic [CNT_W-1:0] cc, input logic [13:0] old);
    logic [79:0] num, den, q;
    num = (80'(gs) * 80'(cc)) << 8;
    den = 80'(cs) * 80'(gc);
    if (den == 80'h0) return old;
    q = num / den;
    return (q > 80'(CGAIN_MAX)) ? CGAIN_MAX : clamp(q[13:0], GAIN_ONE,
      CGAIN_MAX);
  endfunction : grey_gain

  // bus handshakes: write address and data are taken together
  assign wr_go = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !bvalid_ff;
  assign rd_go = S_AXI_ARVALID_IN && !rvalid_ff;
  assign S_AXI_AWREADY_OUT = wr_go;
  assign S_AXI_WREADY_OUT = wr_go;
  assign S_AXI_ARREADY_OUT = !rvalid_ff;
  assign wr_addr = {S_AXI_AWADDR_IN[7:2], 2'b00};
  assign rd_addr = {S_AXI_ARADDR_IN[7:2], 2'b00};
  assign awb_req = wr_go && wr_addr == OFF_AWB && S_AXI_WSTRB_IN[0] &&
                   S_AXI_WDATA_IN[0];
  assign awb_busy = awb_st_ff != AWB_IDLE;
  // nominal link rate follows the select
  assign link_mhz = speed_ff ? LINK_MHZ_SLOW : LINK_MHZ_FAST;
  assign LINK_CLK_SEL_OUT = speed_ff;

  // byte-lane merge of the write data into the addressed register
  always_comb begin
    rd_word = reg_value(rd_addr);
    wr_word = reg_value(wr_addr);
    for (int i = 0; i < 4; i++) begin
      if (S_AXI_WSTRB_IN[i]) wr_word[i*8 +: 8] = S_AXI_WDATA_IN[i*8 +: 8];
    end
  end

  // write response, error on unmapped words
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= reg_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read data registered one cycle after the address
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= reg_known(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rd_word;
    end else if (S_AXI_RREADY_IN) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;
  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;

  // settings; illegal widths and tap counts are ignored, ranges clamp
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      width_ff <= WIDTH_12;
      taps_ff <= TAPS_10;
      speed_ff <= 1'b0;
      hot_ff <= 1'b0;
      dpc_ff <= 1'b0;
      wb_x_ff <= 16'h0000;
      wb_y_ff <= 16'h0000;
      wb_w_ff <= 16'h0000;
      wb_h_ff <= 16'h0000;
      gain_r_ff <= GAIN_ONE;
      gain_g_ff <= GAIN_ONE;
      gain_b_ff <= GAIN_ONE;
      dgain_ff <= GAIN_ONE;
      black_ff <= 8'h00;
      thr_hi_ff <= THR_MAX;
      thr_lo_ff <= THR_MAX;
    end else begin
      if (wr_go) begin
        case (wr_addr)
          OFF_CTRL: begin
            if (wr_word[CTRL_WIDTH_LSB +: 4] inside {WIDTH_8, WIDTH_10,
                WIDTH_12}) width_ff <= wr_word[CTRL_WIDTH_LSB +: 4];
            if (wr_word[CTRL_TAPS_LSB +: 4] inside {TAPS_2, TAPS_4, TAPS_8,
                TAPS_10}) taps_ff <= wr_word[CTRL_TAPS_LSB +: 4];
            speed_ff <= wr_word[CTRL_SPEED_BIT];
            hot_ff <= wr_word[CTRL_HOT_BIT];
            dpc_ff <= wr_word[CTRL_DPC_BIT];
          end
          OFF_WB_X: wb_x_ff <= wr_word[15:0];
          OFF_WB_Y: wb_y_ff <= wr_word[15:0];
          OFF_WB_W: wb_w_ff <= wr_word[15:0];
          OFF_WB_H: wb_h_ff <= wr_word[15:0];
          // colour gains held within 1.0 to 4.0
          OFF_GAIN_R: gain_r_ff <= clamp(wr_word[13:0], GAIN_ONE, CGAIN_MAX);
          OFF_GAIN_G: gain_g_ff <= clamp(wr_word[13:0], GAIN_ONE, CGAIN_MAX);
          OFF_GAIN_B: gain_b_ff <= clamp(wr_word[13:0], GAIN_ONE, CGAIN_MAX);
          OFF_DGAIN: dgain_ff <= clamp(wr_word[13:0], GAIN_ONE, DGAIN_MAX);
          OFF_BLACK: black_ff <= wr_word[7:0];
          OFF_THR_HI: thr_hi_ff <= 12'(clamp(wr_word[13:0], 14'h0000,
            14'(THR_MAX)));
          OFF_THR_LO: thr_lo_ff <= 12'(clamp(wr_word[13:0], 14'h0000,
            14'(THR_MAX)));
          default: ;
        endcase
      end
      // red and blue follow green; a solve beats a same-cycle write
      if (awb_st_ff == AWB_SOLVE) begin
        gain_r_ff <= grey_gain(sum_ff[1], num_ff[1], sum_ff[0], num_ff[0],
          gain_r_ff);
        gain_b_ff <= grey_gain(sum_ff[1], num_ff[1], sum_ff[2], num_ff[2],
          gain_b_ff);
      end
    end
  end

  // one-shot balance: arm, gather one frame, solve, idle
  always_comb begin
    nxt_awb_st = awb_st_ff;
    unique case (awb_st_ff)
      AWB_IDLE: if (awb_req) nxt_awb_st = AWB_ARMED;
      AWB_ARMED: if (pix_take && PIX_IN.sof) nxt_awb_st = AWB_GATHER;
      AWB_GATHER: if (pix_take && PIX_IN.sof) nxt_awb_st = AWB_SOLVE;
      AWB_SOLVE: nxt_awb_st = AWB_IDLE;
    endcase
  end
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) awb_st_ff <= AWB_IDLE;
    else awb_st_ff <= nxt_awb_st;
  end

  // window test; an empty window means the whole image
  assign wb_set = wb_w_ff != 16'h0000 && wb_h_ff != 16'h0000;
  assign x_end = 17'(wb_x_ff) + 17'(wb_w_ff);
  assign y_end = 17'(wb_y_ff) + 17'(wb_h_ff);
  assign in_wb = !wb_set || (PIX_IN.x >= wb_x_ff && 17'(PIX_IN.x) < x_end &&
                 PIX_IN.y >= wb_y_ff && 17'(PIX_IN.y) < y_end);
  assign col_idx = (PIX_IN.colour == COL_R) ? 2'h0 :
                   (PIX_IN.colour == COL_B) ? 2'h2 : 2'h1;
  // statistics of corrected pixels; the stream is already the image region
  assign stat_en = pix_take && in_wb &&
    ((awb_st_ff == AWB_ARMED && PIX_IN.sof) ||
     (awb_st_ff == AWB_GATHER && !PIX_IN.sof));
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || awb_st_ff == AWB_IDLE) begin
      sum_ff <= '0;
      num_ff <= '0;
    end else if (stat_en) begin
      sum_ff[col_idx] <= sum_ff[col_idx] + SUM_W'(fixed_pix);
      num_ff[col_idx] <= num_ff[col_idx] + CNT_W'(1);
    end
  end

  // defect fix first, then colour and digital gain
  pix_median u_fix (
    .win_in(PIX_IN.win),
    .hot_en_in(hot_ff),
    .dpc_en_in(dpc_ff),
    .thr_hi_in(thr_hi_ff),
    .thr_lo_in(thr_lo_ff),
    .pix_out(fixed_pix)
  );
  // each colour uses its own gain
  assign col_gain = (col_idx == 2'h0) ? gain_r_ff :
                    (col_idx == 2'h2) ? gain_b_ff : gain_g_ff;
  pix_gain_sat u_colour (
    .pix_in(fixed_pix),
    .gain_in(col_gain),
    .pix_out(wb_pix)
  );
  pix_gain_sat u_digital (
    .pix_in(wb_pix),
    .gain_in(dgain_ff),
    .pix_out(dg_pix)
  );
  // black offset added on 12-bit scale, clipped at full scale
  assign blk_sum = 13'(dg_pix) + 13'(black_ff);
  assign blk_pix = blk_sum[12] ? PIX_MAX : blk_sum[11:0];
  // width reduction keeps the top bits, so the clip maps to full code
  assign out_pix = (width_ff == WIDTH_8) ? {4'h0, blk_pix[11:4]} :
                   (width_ff == WIDTH_10) ? {2'h0, blk_pix[11:2]} : blk_pix;

  // pixel n of a word lands on tap n, earlier pixels kept
  always_comb begin
    nxt_word = '0;
    for (int i = 0; i < MAX_TAPS; i++) begin
      if (4'(i) < cnt_ff) nxt_word[i] = slot_ff[i];
      else if (4'(i) == cnt_ff) nxt_word[i] = out_pix;
    end
  end
  // a word is complete after as many pixels as taps
  assign last_tap = cnt_ff >= taps_ff - 4'h1;
  assign word_done = pix_take && last_tap;
  // stall only when a finished word has nowhere to go
  assign PIX_READY_OUT = !(hold_full_ff && last_tap);
  assign pix_take = PIX_VALID_IN && PIX_READY_OUT;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      cnt_ff <= 4'h0;
      slot_ff <= '0;
    end else if (pix_take) begin
      cnt_ff <= word_done ? 4'h0 : cnt_ff + 4'h1;
      slot_ff <= nxt_word;
    end
  end

  // link clock sampled twice, third stage only for the edge
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      lk_s1_ff <= 1'b0;
      lk_s2_ff <= 1'b0;
      lk_s3_ff <= 1'b0;
    end else begin
      lk_s1_ff <= LINK_CLK_IN;
      lk_s2_ff <= lk_s1_ff;
      lk_s3_ff <= lk_s2_ff;
    end
  end
  assign link_rise = lk_s2_ff && !lk_s3_ff;

  // hold word waits for a link edge; loading wins over draining
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      hold_full_ff <= 1'b0;
      hold_taps_ff <= '0;
    end else if (word_done) begin
      hold_full_ff <= 1'b1;
      hold_taps_ff <= nxt_word;
    end else if (link_rise) begin
      hold_full_ff <= 1'b0;
    end
  end

  // one word per link cycle, valid low when none is ready
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) link_ff <= '0;
    else if (link_rise) link_ff <= {hold_full_ff,
      hold_full_ff ? hold_taps_ff : {MAX_TAPS{12'h000}}};
  end
  assign LINK_OUT = link_ff;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_width_eight:
    assert property (pix_take && width_ff == WIDTH_8 |-> out_pix[11:8] == 4'h0)
    else $error("8-bit pixel uses upper bits");
  a_unused_taps:
    assert property (word_done && taps_ff == TAPS_2 |=>
      hold_full_ff && hold_taps_ff[2] == 12'h000)
    else $error("tap beyond count is not zero");
  a_tap_order:
    assert property (word_done && taps_ff == TAPS_4 |=>
      hold_taps_ff[3] == $past(out_pix) &&
      hold_taps_ff[0] == $past(slot_ff[0]))
    else $error("pixels out of tap order");
  a_link_emit:
    assert property (link_rise && hold_full_ff |=> LINK_OUT.dval &&
      !hold_full_ff && LINK_OUT.taps == $past(hold_taps_ff))
    else $error("link word not emitted once");
  a_link_idle:
    assert property (link_rise && !hold_full_ff |=> !LINK_OUT.dval)
    else $error("link valid without a word");
  a_speed_status:
    assert property (rd_go && rd_addr == OFF_STATUS && speed_ff |=>
      S_AXI_RDATA_OUT[15:8] == LINK_MHZ_SLOW)
    else $error("link rate status wrong");
  a_wb_outside:
    assert property (pix_take && !in_wb && awb_busy |=> $stable(sum_ff))
    else $error("pixel outside window counted");
  a_gain_range:
    assert property (gain_r_ff >= GAIN_ONE && gain_r_ff <= CGAIN_MAX &&
      gain_b_ff >= GAIN_ONE && gain_b_ff <= CGAIN_MAX)
    else $error("colour gain out of range");
  a_unity_pass:
    assert property (pix_take && col_gain == GAIN_ONE && dgain_ff == GAIN_ONE
      && black_ff == 8'h00 && width_ff == WIDTH_12 |-> out_pix == fixed_pix)
    else $error("unity gain changed pixel");
  a_awb_once:
    assert property (awb_st_ff == AWB_SOLVE |=> awb_st_ff == AWB_IDLE)
    else $error("balance did not return idle");
  a_dgain_range:
    assert property (dgain_ff >= GAIN_ONE && dgain_ff <= DGAIN_MAX)
    else $error("digital gain out of range");
  a_dpc_bypass:
    assert property (!dpc_ff && !hot_ff |-> fixed_pix == PIX_IN.win[4])
    else $error("correction active while off");
  a_black_sat:
    assert property (pix_take && width_ff == WIDTH_12 && dg_pix == PIX_MAX
      |-> out_pix == PIX_MAX)
    else $error("black offset wrapped");

  c_awb_solve: cover property (awb_st_ff == AWB_SOLVE);
  c_ten_taps: cover property (word_done && taps_ff == TAPS_10);
  c_link_word: cover property (link_rise && hold_full_ff);
  c_defect_fix: cover property (pix_take && dpc_ff &&
    fixed_pix != PIX_IN.win[4]);
endmodule : camera_pixel_output_pipeline
`default_nettype wire

/* tb/link_grabber.sv */
// frame grabber model: link clock source and tap word capture
`timescale 1ns/1ps
`default_nettype none
module link_grabber import pix_pkg::*; (
  input wire link_out_t link_in, // tap word from the camera
  output logic link_clk_out, // free running link clock
  output var link_out_t word_out, // last word with data valid
  output var int words_out // count of valid words
);
  // link clock runs free; odd start keeps it out of phase with the core
  initial begin
    link_clk_out = 1'b0;
    words_out = 0;
    word_out = '0;
    #7;
    forever #100 link_clk_out = ~link_clk_out;
  end
  // sample mid-period, well after the word has settled
  always @(negedge link_clk_out) begin
    if (link_in.dval === 1'b1) begin
      word_out <= link_in;
      words_out <= words_out + 1;
    end
  end
endmodule : link_grabber
`default_nettype wire

/* tb/tb.sv */
// bench: register access, pixel path, tap packing and auto balance
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pix_pkg::*;
  logic clk, rst, awv, wv, arv, pv, awr, wrr, bv, arr, rv, pr, sel, lclk;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] rsp, br, rr;
  pix_in_t pix;
  link_out_t lout, word;
  int words, mismatches, samples_checked, cyc;
  camera_pixel_output_pipeline u_camera_pixel_output_pipeline (
    .CLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awa),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrr),
    .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(1'b1),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(1'b1), .PIX_IN(pix), .PIX_VALID_IN(pv),
    .PIX_READY_OUT(pr), .LINK_CLK_IN(lclk), .LINK_OUT(lout),
    .LINK_CLK_SEL_OUT(sel));
  link_grabber u_link_grabber (.link_in(lout), .link_clk_out(lclk),
    .word_out(word), .words_out(words));
  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out;
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // ready is combinational, so it is sampled before the edge lands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1 || wrr !== 1'b1);
    awv <= 1'b0; wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    rsp = br;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    ara <= a; arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    cmp(rdat, e);
    cmp(rr, er);
  endtask : rchk
  task automatic px(input logic s, input logic [1:0] col,
      input logic [11:0] c, input logic [11:0] n);
    pix.sof <= s; pix.colour <= col; pix.win <= {{4{n}}, c, {4{n}}};
    pv <= 1'b1;
    do @(posedge clk); while (pr !== 1'b1);
  endtask : px
  // one tap word: pixel i carries centre c+i*s, expected e+i*s
  task automatic run(input logic [31:0] ct, g, dg, bl, input logic [1:0] col,
      input logic [11:0] c, n, e, s);
    int w;
    wr(OFF_CTRL, ct); wr(OFF_GAIN_R, g); wr(OFF_DGAIN, dg); wr(OFF_BLACK, bl);
    w = words;
    for (int i = 0; i < ct[7:4]; i++)
      px(1'b0, col, 12'(c + i * s), 12'(n + i * s));
    pv <= 1'b0;
    do @(posedge clk); while (words == w);
    for (int i = 0; i < 10; i++) cmp(word.taps[i], i < ct[7:4] ? e + i * s : 0);
  endtask : run
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {awv, wv, arv, pv, awa, ara, wd, pix, cyc} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(OFF_CTRL, 32'h0AC, RESP_OKAY);
    rchk(OFF_STATUS, 32'h5500, RESP_OKAY);
    rchk(OFF_THR_HI, 32'h800, RESP_OKAY);
    rchk(8'h3C, 32'h0, RESP_SLVERR);
    wr(8'h3C, 32'h1); cmp(rsp, RESP_SLVERR);
    wr(OFF_THR_LO, 32'hFFF); rchk(OFF_THR_LO, 32'h800, RESP_OKAY);
    wr(OFF_GAIN_R, 32'hFFFF); rchk(OFF_GAIN_R, 32'h400, RESP_OKAY);
    wr(OFF_WB_W, 32'h1234); rchk(OFF_WB_W, 32'h1234, RESP_OKAY);
    wr(OFF_CTRL, 32'h12C); cmp(sel, 1'b1);
    rchk(OFF_STATUS, 32'h4100, RESP_OKAY);
    wr(OFF_WB_W, 32'h0);
    run(32'h04C, 32'h100, 32'h100, 0, 1, 12'h123, 12'h123, 12'h123, 12'h111);
    run(32'h08C, 32'h100, 32'h100, 0, 1, 12'h010, 12'h010, 12'h010, 12'h010);
    run(32'h0AC, 32'h100, 32'h100, 0, 1, 12'h010, 12'h010, 12'h010, 12'h010);
    run(32'h02C, 32'h200, 32'h100, 0, 0, 12'h123, 12'h123, 12'h246, 0);
    cmp(sel, 1'b0);
    run(32'h02C, 32'h100, 32'h200, 32'h10, 1, 12'h123, 12'h123, 12'h256, 0);
    run(32'h028, 32'h100, 32'h100, 0, 1, 12'h123, 12'h123, 12'h012, 0);
    run(32'h02A, 32'h100, 32'h100, 0, 1, 12'h123, 12'h123, 12'h048, 0);
    run(32'h02C, 32'h400, 32'h2000, 32'hFF, 0, 12'h800, 12'h800, 12'hFFF, 0);
    run(32'h02C, 32'h100, 32'h100, 0, 1, 12'hFFF, 12'h100, 12'hFFF, 0);
    run(32'h42C, 32'h100, 32'h100, 0, 1, 12'hFFF, 12'h100, 12'h100, 0);
    run(32'h22C, 32'h100, 32'h100, 0, 1, 12'hFFF, 12'h100, 12'h100, 0);
    run(32'h42C, 32'h100, 32'h100, 0, 1, 12'h600, 12'h100, 12'h600, 0);
    wr(OFF_THR_HI, 32'h0);
    run(32'h42C, 32'h100, 32'h100, 0, 1, 12'h600, 12'h100, 12'h100, 0);
    wr(OFF_CTRL, 32'h02C); wr(OFF_GAIN_B, 32'h100); wr(OFF_AWB, 32'h1);
    px(1, 1, 12'h200, 12'h200); px(0, 0, 12'h100, 12'h100);
    px(0, 2, 12'h080, 12'h080); px(0, 1, 12'h200, 12'h200);
    px(1, 1, 12'h200, 12'h200); px(0, 1, 12'h200, 12'h200);
    pv <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(OFF_GAIN_R, 32'h200, RESP_OKAY);
    rchk(OFF_GAIN_B, 32'h400, RESP_OKAY);
    rchk(OFF_GAIN_G, 32'h100, RESP_OKAY);
    rchk(OFF_AWB, 32'h0, RESP_OKAY);
    // only x 1, y 0 lies in the window; blue sees no pixel and keeps its gain
    wr(OFF_WB_X, 32'h1); wr(OFF_WB_W, 32'h1); wr(OFF_WB_H, 32'h1);
    wr(OFF_GAIN_R, 32'h100); wr(OFF_AWB, 32'h1);
    px(1, 1, 12'h200, 12'h200); pix.x <= 16'h0001;
    px(0, 1, 12'h200, 12'h200); px(0, 0, 12'h100, 12'h100);
    pix.x <= 16'h0000;
    px(0, 0, 12'h080, 12'h080); px(1, 1, 12'h200, 12'h200);
    px(0, 1, 12'h200, 12'h200);
    pv <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(OFF_GAIN_R, 32'h200, RESP_OKAY);
    rchk(OFF_GAIN_B, 32'h400, RESP_OKAY);
    close_out();
  end
endmodule : tb
`default_nettype wire
